// ==== dv/dct_pin.sv ====
`timescale 1ns/10ps
`default_nettype none
module dct_pin (
	input wire logic ref_clk,
	output var logic edge_pin
);
	initial edge_pin = 1'b0;
	// each level held at least four clocks, so the sync never loses one
	task automatic flip(input int n);
		@(negedge ref_clk);
		edge_pin = ~edge_pin;
		repeat ((n > 3 ? n : 4) - 1) @(negedge ref_clk);
	endtask
endmodule
`default_nettype wire

// ==== dv/dct_timers_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
module dct_timers_chk (
	input wire logic       ref_clk,
	input wire logic       reset_n,
	input wire logic       stop_recover,
	input wire logic [3:0] reg_addr,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       edge_pin,
	input wire logic       short_capture_irq,
	input wire logic       short_timeout_irq,
	input wire logic       wide_capture_irq,
	input wire logic       wide_timeout_irq
);
	logic [7:0] ctl0_reg;
	logic [7:0] ctl2_reg;
	logic [7:0] hold_reg;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	// software view only; the flags belong to the hardware, so left out
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctl0_reg <= 8'h00;
			ctl2_reg <= 8'h00;
			hold_reg <= 8'h00;
		end else if (stop_recover) begin
			ctl0_reg <= ctl0_reg & 8'h3E;
			ctl2_reg <= ctl2_reg & 8'h3E;
		end else if (reg_wr) begin
			if (reg_addr == 4'h0) ctl0_reg <= reg_wdata & 8'hDF;
			if (reg_addr == 4'h2) ctl2_reg <= reg_wdata & 8'hDF;
			if (reg_addr == 4'h4) hold_reg <= reg_wdata;
		end
	end
	short_pulse_a: assert property (short_capture_irq |=> !short_capture_irq [*2])
		else $error("capture pulse too long");
	cap_gate_a: assert property (short_capture_irq |-> ctl0_reg[2])
		else $error("capture irq with mask clear");
	tout_gate_a: assert property (short_timeout_irq |-> ctl0_reg[1])
		else $error("timeout irq with mask clear");
	wide_cap_gate_a: assert property (wide_capture_irq |-> ctl2_reg[2])
		else $error("wide capture irq with mask clear");
	wide_tout_gate_a: assert property (wide_timeout_irq |-> ctl2_reg[1])
		else $error("wide timeout irq with mask clear");
	ctl_keep_a: assert property (reg_rd && reg_addr == 4'h0 |=> (reg_rdata & 8'hDF) == $past(ctl0_reg))
		else $error("control readback wrong");
	hold_read_a: assert property (reg_rd && reg_addr == 4'h4 |=> reg_rdata == $past(hold_reg))
		else $error("hold readback wrong");
	void_read_a: assert property (reg_rd && (reg_addr == 4'h3 || reg_addr > 4'hB) |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
endmodule
bind dct_timers dct_timers_chk u_dct_timers_chk (
	.ref_clk(ref_clk), .reset_n(reset_n), .stop_recover(stop_recover), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .edge_pin(edge_pin),
	.short_capture_irq(short_capture_irq), .short_timeout_irq(short_timeout_irq),
	.wide_capture_irq(wide_capture_irq), .wide_timeout_irq(wide_timeout_irq)
);
`default_nettype wire

// ==== dv/dct_timers_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module dct_timers_tb;
	logic        ref_clk, reset_n, stop_recover, reg_wr, reg_rd, edge_pin;
	logic        sc_irq, st_irq, wc_irq, wt_irq;
	logic [3:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, hi, lo;
	logic [8:0]  mon_e;
	logic [8:0]  exp_q[$];
	logic [15:0] cap[2];
	logic [31:0] rng;
	int          n_errors = 0;
	int          n_compared = 0;
	int          cnt[4] = '{0, 0, 0, 0};
	int          a, b;
	int          gap[2];

	dct_timers u_dct_timers (.ref_clk(ref_clk), .reset_n(reset_n), .stop_recover(stop_recover),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.edge_pin(edge_pin), .short_capture_irq(sc_irq), .short_timeout_irq(st_irq),
		.wide_capture_irq(wc_irq), .wide_timeout_irq(wt_irq));
	dct_pin u_dct_pin (.ref_clk(ref_clk), .edge_pin(edge_pin));

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		n_errors++;
		complete_run();
	end

	task automatic complete_run();
		if (n_errors == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	// monitor pairs each read result with the oldest note
	always @(posedge ref_clk) begin
		cnt[0] += int'(sc_irq === 1'b1);
		cnt[1] += int'(st_irq === 1'b1);
		cnt[2] += int'(wc_irq === 1'b1);
		cnt[3] += int'(wt_irq === 1'b1);
		if (reg_rd === 1'b1) begin
			@(negedge ref_clk);
			mon_e = exp_q.pop_front();
			if (mon_e[8]) chk({8'h00, reg_rdata}, {8'h00, mon_e[7:0]});
		end
	end

	function automatic int pick();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return 8 + int'(rng % 32'd60);
	endfunction

	task automatic wr(input logic [3:0] ad, input logic [7:0] d);
		@(negedge ref_clk);
		reg_addr = ad;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge ref_clk);
		reg_wr = 1'b0;
	endtask

	task automatic rd(input logic [3:0] ad, input logic [7:0] e, input logic use_e, output logic [7:0] d);
		@(negedge ref_clk);
		reg_addr = ad;
		reg_rd = 1'b1;
		exp_q.push_back({use_e, e});
		@(negedge ref_clk);
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask

	task automatic rx(input logic [3:0] ad, input logic [7:0] e);
		logic [7:0] d;
		rd(ad, e, 1'b1, d);
	endtask

	task automatic fp(input int n);
		u_dct_pin.flip(n);
	endtask

	initial begin
		rng = 32'h0000_46f6;
		reset_n = 1'b0;
		stop_recover = 1'b0;
		reg_addr = 4'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
		repeat (6) @(posedge ref_clk);
		@(negedge ref_clk);
		reset_n = 1'b1;
		rx(4'h0, 8'h00);
		a = pick();
		wr(4'h4, 8'(a));
		rx(4'h4, 8'(a));
		wr(4'h3, 8'hFF);
		rx(4'h3, 8'h00);
		rx(4'hF, 8'h00);
		// holds written only while stopped, never mid-reload
		wr(4'h4, 8'hFF);
		wr(4'h5, 8'hFF);
		wr(4'h1, 8'h20);
		wr(4'h0, 8'h84);
		repeat (4) @(negedge ref_clk);
		a = pick();
		b = pick();
		fp(a);
		fp(b);
		fp(8);
		rd(4'h9, 8'h00, 1'b0, hi);
		rd(4'h8, 8'h00, 1'b0, lo);
		chk({8'h00, 8'(hi - lo)}, {8'h00, 8'(a - b)});
		rx(4'h1, 8'h23);
		chk(16'(cnt[0]), 16'd2);
		wr(4'h0, 8'h04);
		wr(4'h1, 8'h23);
		rx(4'h1, 8'h20);
		wr(4'h1, 8'h10);
		wr(4'h0, 8'h80);
		repeat (4) @(negedge ref_clk);
		a = pick();
		fp(6);
		fp(a);
		fp(6);
		fp(8);
		rd(4'h8, 8'h00, 1'b0, hi);
		chk({8'h00, 8'(hi - lo)}, {8'h00, 8'(a + 6 - b)});
		rx(4'h1, 8'h12);
		chk(16'(cnt[0]), 16'd2);
		wr(4'h0, 8'h00);
		wr(4'h1, 8'h12);
		wr(4'h0, 8'h82);
		repeat (4) @(negedge ref_clk);
		fp(6);
		fp(6);
		repeat (300) @(negedge ref_clk);
		wr(4'h0, 8'h02);
		rx(4'h0, 8'h22);
		chk(16'(cnt[1]), 16'd1);
		wr(4'h0, 8'h02);
		rx(4'h0, 8'h22);
		wr(4'h0, 8'h22);
		rx(4'h0, 8'h02);
		wr(4'h0, 8'h9F);
		@(negedge ref_clk);
		stop_recover = 1'b1;
		@(negedge ref_clk);
		stop_recover = 1'b0;
		rx(4'h0, 8'h1E);
		wr(4'h0, 8'h00);
		wr(4'h6, 8'hFF);
		wr(4'h7, 8'hFF);
		for (int i = 0; i < 2; i++) begin
			a = pick();
			wr(4'h2, 8'h84);
			repeat (4) @(negedge ref_clk);
			fp(6);
			fp(6);
			fp(a);
			fp(8);
			wr(4'h2, 8'h04);
			rd(4'hB, 8'h00, 1'b0, hi);
			rd(4'hA, 8'h00, 1'b0, lo);
			cap[i] = {hi, lo};
			gap[i] = a;
		end
		chk(16'(cap[1] - cap[0]), 16'(gap[1] - gap[0]));
		chk(16'(cnt[2]), 16'd4);
		rx(4'h1, 8'h12);
		wr(4'h1, 8'h12);
		// zero holds, never a count of one
		wr(4'h6, 8'h00);
		wr(4'h7, 8'h00);
		wr(4'h2, 8'h82);
		repeat (4) @(negedge ref_clk);
		fp(6);
		fp(6);
		repeat (300) @(negedge ref_clk);
		rx(4'h2, 8'h82);
		chk(16'(cnt[3]), 16'd0);
		// short wide count so a real one-to-zero timeout is seen
		wr(4'h2, 8'h02);
		wr(4'h6, 8'h40);
		wr(4'h2, 8'h82);
		repeat (4) @(negedge ref_clk);
		fp(6);
		fp(6);
		repeat (80) @(negedge ref_clk);
		wr(4'h2, 8'h02);
		rx(4'h2, 8'h22);
		chk(16'(cnt[3]), 16'd1);
		complete_run();
	end
endmodule
`default_nettype wire

// ==== rtl/dct_defs.svh ====
`ifndef DCT_DEFS_SVH
`define DCT_DEFS_SVH

// register offsets inside the expanded bank
`define DCT_OFS_SHORT_CTRL     4'h0
`define DCT_OFS_EDGE_CTRL      4'h1
`define DCT_OFS_WIDE_CTRL      4'h2
`define DCT_OFS_SHORT_LO_HOLD  4'h4
`define DCT_OFS_SHORT_HI_HOLD  4'h5
`define DCT_OFS_WIDE_LO_HOLD   4'h6
`define DCT_OFS_WIDE_HI_HOLD   4'h7
`define DCT_OFS_SHORT_CAP_LO   4'h8
`define DCT_OFS_SHORT_CAP_HI   4'h9
`define DCT_OFS_WIDE_CAP_LO    4'hA
`define DCT_OFS_WIDE_CAP_HI    4'hB

// control field positions
`define DCT_BIT_ENABLE         7
`define DCT_BIT_MODE           6
`define DCT_BIT_TIMEOUT        5
`define DCT_BIT_CLK_HI         4
`define DCT_BIT_CLK_LO         3
`define DCT_BIT_CAP_MASK       2
`define DCT_BIT_TO_MASK        1
`define DCT_BIT_OUT_SEL        0
`define DCT_BIT_ESEL_HI        5
`define DCT_BIT_ESEL_LO        4
`define DCT_BIT_RISE_FLAG      1
`define DCT_BIT_FALL_FLAG      0

// edge select encodings
`define DCT_ESEL_FALL          2'h0
`define DCT_ESEL_RISE          2'h1

// prescaler selections
`define DCT_DIV1               2'h0
`define DCT_DIV2               2'h1
`define DCT_DIV4               2'h2

// values
`define DCT_ONES8              8'hFF
`define DCT_ONES16             16'hFFFF
`define DCT_ZERO8              8'h00
`define DCT_ZERO16             16'h0000
`define DCT_ONE8               8'h01
`define DCT_ONE16              16'h0001
`define DCT_ZERO2              2'h0
`define DCT_ZERO3              3'h0

`endif

// ==== rtl/dct_edge_sync.sv ====
`timescale 1ns/10ps
`default_nettype none

module dct_edge_sync (
	input  wire logic ref_clk,
	input  wire logic reset_n,
	input  wire logic edge_pin,
	output logic      rise_pulse,
	output logic      fall_pulse
);

	logic meta_reg;
	logic sync_reg;
	logic prev_reg;

	// two stages before anyone looks at the pin
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			prev_reg <= 1'b0;
		end else begin
			meta_reg <= edge_pin;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	// one pulse per transition
	assign rise_pulse = sync_reg & ~prev_reg; // RULE20
	assign fall_pulse = ~sync_reg & prev_reg; // RULE20

endmodule

`default_nettype wire

// ==== rtl/dct_pkg.sv ====
package dct_pkg;

	typedef enum logic [1:0] {
		DCT_IDLE  = 2'b00,
		DCT_ARMED = 2'b01,
		DCT_COUNT = 2'b10
	} dct_state_e;

endpackage

// ==== rtl/dct_timers.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "dct_defs.svh"

// Summary of operation
// RULE1 - software presets short holds to all ones
// RULE2 - short timer starts on first selected edge
// RULE3 - later edges capture complemented short count
// RULE4 - rising to low capture, falling to high
// RULE5 - capture sets edge flag, masked interrupt
// RULE6 - short timer reloads ones after capture
// RULE7 - short timeout flag, write one clears
// RULE8 - interrupt masks gate, cleared at power-on
// RULE9 - marked fields survive stop-mode recovery
// RULE10 - software stops first, clears status later
// RULE11 - commands act one timer tick later
// RULE12 - software avoids hold writes during reload
// RULE13 - software never loads wide count one
// RULE14 - wide zero wraps to ones, no timeout
// RULE15 - software presets wide holds to all ones
// RULE16 - wide first edge captures, reloads, starts
// RULE17 - mode bit clear: later edges capture
// RULE18 - wide capture sets flag, masked interrupt
// RULE19 - wide timer reloads ones after capture
// RULE20 - input pin synchronised, one event per edge
module dct_timers
	import dct_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	input  wire logic       stop_recover,
	input  wire logic [3:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	input  wire logic       edge_pin,
	output logic            short_capture_irq,
	output logic            short_timeout_irq,
	output logic            wide_capture_irq,
	output logic            wide_timeout_irq
);

	function automatic logic presc_tick(input logic [2:0] cnt, input logic [1:0] sel);
		case (sel)
			`DCT_DIV1: presc_tick = 1'b1;
			`DCT_DIV2: presc_tick = cnt[0];
			`DCT_DIV4: presc_tick = &cnt[1:0];
			default:   presc_tick = &cnt;
		endcase
	endfunction

	logic       rise_ev;
	logic       fall_ev;
	logic [2:0] presc_reg;
	logic [7:0] sctl_reg;
	logic [1:0] esel_reg;
	logic       rise_flag_reg;
	logic       fall_flag_reg;
	logic [7:0] wctl_reg;
	logic [7:0] s_lo_hold_reg;
	logic [7:0] s_hi_hold_reg;
	logic [7:0] w_lo_hold_reg;
	logic [7:0] w_hi_hold_reg;
	logic [7:0] s_cap_lo_reg;
	logic [7:0] s_cap_hi_reg;
	logic [15:0] w_cap_reg;
	logic       s_run_reg;
	logic       w_run_reg;
	logic [7:0] s_cnt_reg;
	logic [15:0] w_cnt_reg;
	dct_state_e s_state_reg;
	dct_state_e w_state_reg;

	logic       qual_ev;
	logic       s_tick;
	logic       w_tick;
	logic       s_cap_ev;
	logic       s_to_ev;
	logic       w_cap_ev;
	logic       w_to_ev;
	logic       wr_sctl;
	logic       wr_ectl;
	logic       wr_wctl;

	dct_edge_sync u_sync (
		.ref_clk    (ref_clk),
		.reset_n    (reset_n),
		.edge_pin   (edge_pin),
		.rise_pulse (rise_ev),
		.fall_pulse (fall_ev)
	);

	always_comb begin
		case (esel_reg)
			`DCT_ESEL_FALL: qual_ev = fall_ev;
			`DCT_ESEL_RISE: qual_ev = rise_ev;
			default:        qual_ev = rise_ev | fall_ev;
		endcase
	end

	assign wr_sctl = reg_wr && (reg_addr == `DCT_OFS_SHORT_CTRL);
	assign wr_ectl = reg_wr && (reg_addr == `DCT_OFS_EDGE_CTRL);
	assign wr_wctl = reg_wr && (reg_addr == `DCT_OFS_WIDE_CTRL);

	// shared free-running prescaler
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			presc_reg <= `DCT_ZERO3;
		else
			presc_reg <= presc_reg + 3'h1;
	end

	assign s_tick = presc_tick(presc_reg, sctl_reg[`DCT_BIT_CLK_HI:`DCT_BIT_CLK_LO]);
	assign w_tick = presc_tick(presc_reg, wctl_reg[`DCT_BIT_CLK_HI:`DCT_BIT_CLK_LO]);

	// enables reach the counters only on their own tick
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_run_reg <= 1'b0;
			w_run_reg <= 1'b0;
		end else begin
			if (s_tick)
				s_run_reg <= sctl_reg[`DCT_BIT_ENABLE]; // RULE11
			if (w_tick)
				w_run_reg <= wctl_reg[`DCT_BIT_ENABLE]; // RULE11
		end
	end

	assign s_cap_ev = (s_state_reg == DCT_COUNT) && s_run_reg && qual_ev; // RULE3
	assign s_to_ev  = (s_state_reg == DCT_COUNT) && s_run_reg && !qual_ev && s_tick
		&& (s_cnt_reg == `DCT_ONE8); // RULE7
	assign w_cap_ev = w_run_reg && qual_ev && ((w_state_reg == DCT_ARMED) // RULE16
		|| ((w_state_reg == DCT_COUNT) && !wctl_reg[`DCT_BIT_MODE])); // RULE17
	// passing zero wraps silently; only one-to-zero is a timeout
	assign w_to_ev  = (w_state_reg == DCT_COUNT) && w_run_reg && !w_cap_ev && w_tick
		&& (w_cnt_reg == `DCT_ONE16); // RULE14

	// short timer sequencer
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_state_reg <= DCT_IDLE;
			s_cnt_reg   <= `DCT_ZERO8;
		end else begin
			case (s_state_reg)
				DCT_IDLE: begin
					if (s_run_reg)
						s_state_reg <= DCT_ARMED;
				end
				DCT_ARMED: begin
					if (!s_run_reg)
						s_state_reg <= DCT_IDLE;
					else if (qual_ev) begin
						s_cnt_reg   <= s_lo_hold_reg; // RULE2
						s_state_reg <= DCT_COUNT; // RULE2
					end
				end
				DCT_COUNT: begin
					if (!s_run_reg)
						s_state_reg <= DCT_IDLE;
					else if (s_cap_ev)
						s_cnt_reg <= `DCT_ONES8; // RULE6
					else if (s_to_ev)
						s_cnt_reg <= s_lo_hold_reg;
					else if (s_tick)
						s_cnt_reg <= s_cnt_reg - `DCT_ONE8;
				end
				default: s_state_reg <= DCT_IDLE;
			endcase
		end
	end

	// wide timer sequencer
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			w_state_reg <= DCT_IDLE;
			w_cnt_reg   <= `DCT_ZERO16;
		end else begin
			case (w_state_reg)
				DCT_IDLE: begin
					if (w_run_reg)
						w_state_reg <= DCT_ARMED;
				end
				DCT_ARMED: begin
					if (!w_run_reg)
						w_state_reg <= DCT_IDLE;
					else if (w_cap_ev) begin
						w_cnt_reg   <= {w_hi_hold_reg, w_lo_hold_reg}; // RULE16
						w_state_reg <= DCT_COUNT; // RULE16
					end
				end
				DCT_COUNT: begin
					if (!w_run_reg)
						w_state_reg <= DCT_IDLE;
					else if (w_cap_ev)
						w_cnt_reg <= `DCT_ONES16; // RULE19
					else if (w_to_ev)
						w_cnt_reg <= {w_hi_hold_reg, w_lo_hold_reg};
					else if (w_tick)
						w_cnt_reg <= w_cnt_reg - `DCT_ONE16; // RULE14
				end
				default: w_state_reg <= DCT_IDLE;
			endcase
		end
	end

	// capture registers
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_cap_lo_reg <= `DCT_ZERO8;
			s_cap_hi_reg <= `DCT_ZERO8;
			w_cap_reg    <= `DCT_ZERO16;
		end else begin
			if (s_cap_ev && rise_ev)
				s_cap_lo_reg <= ~s_cnt_reg; // RULE4
			if (s_cap_ev && fall_ev)
				s_cap_hi_reg <= ~s_cnt_reg; // RULE4
			if (w_cap_ev)
				w_cap_reg <= ~w_cnt_reg; // RULE17
		end
	end

	// short control: stop-mode recovery clears only the enable, mode and output-select fields
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			sctl_reg <= `DCT_ZERO8; // RULE8
		else begin
			if (wr_sctl) begin
				sctl_reg[`DCT_BIT_ENABLE]                 <= reg_wdata[`DCT_BIT_ENABLE];
				sctl_reg[`DCT_BIT_MODE]                   <= reg_wdata[`DCT_BIT_MODE];
				sctl_reg[`DCT_BIT_CLK_HI:`DCT_BIT_CLK_LO] <= reg_wdata[`DCT_BIT_CLK_HI:`DCT_BIT_CLK_LO];
				sctl_reg[`DCT_BIT_CAP_MASK]               <= reg_wdata[`DCT_BIT_CAP_MASK];
				sctl_reg[`DCT_BIT_TO_MASK]                <= reg_wdata[`DCT_BIT_TO_MASK];
				sctl_reg[`DCT_BIT_OUT_SEL]                <= reg_wdata[`DCT_BIT_OUT_SEL];
			end
			// set wins over a clear in the same cycle
			if (s_to_ev)
				sctl_reg[`DCT_BIT_TIMEOUT] <= 1'b1; // RULE7
			else if (wr_sctl && reg_wdata[`DCT_BIT_TIMEOUT])
				sctl_reg[`DCT_BIT_TIMEOUT] <= 1'b0; // RULE7
			if (stop_recover) begin
				sctl_reg[`DCT_BIT_ENABLE]  <= 1'b0; // RULE9
				sctl_reg[`DCT_BIT_MODE]    <= 1'b0; // RULE9
				sctl_reg[`DCT_BIT_OUT_SEL] <= 1'b0; // RULE9
			end
		end
	end

	// edge control and shared edge flags
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			esel_reg      <= `DCT_ZERO2;
			rise_flag_reg <= 1'b0;
			fall_flag_reg <= 1'b0;
		end else begin
			if (wr_ectl)
				esel_reg <= reg_wdata[`DCT_BIT_ESEL_HI:`DCT_BIT_ESEL_LO];
			if ((s_cap_ev || w_cap_ev) && rise_ev)
				rise_flag_reg <= 1'b1; // RULE5
			else if (wr_ectl && reg_wdata[`DCT_BIT_RISE_FLAG])
				rise_flag_reg <= 1'b0;
			if ((s_cap_ev || w_cap_ev) && fall_ev)
				fall_flag_reg <= 1'b1; // RULE18
			else if (wr_ectl && reg_wdata[`DCT_BIT_FALL_FLAG])
				fall_flag_reg <= 1'b0;
		end
	end

	// wide control
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			wctl_reg <= `DCT_ZERO8;
		else begin
			if (wr_wctl) begin
				wctl_reg[`DCT_BIT_ENABLE]                 <= reg_wdata[`DCT_BIT_ENABLE];
				wctl_reg[`DCT_BIT_MODE]                   <= reg_wdata[`DCT_BIT_MODE];
				wctl_reg[`DCT_BIT_CLK_HI:`DCT_BIT_CLK_LO] <= reg_wdata[`DCT_BIT_CLK_HI:`DCT_BIT_CLK_LO];
				wctl_reg[`DCT_BIT_CAP_MASK]               <= reg_wdata[`DCT_BIT_CAP_MASK];
				wctl_reg[`DCT_BIT_TO_MASK]                <= reg_wdata[`DCT_BIT_TO_MASK];
				wctl_reg[`DCT_BIT_OUT_SEL]                <= reg_wdata[`DCT_BIT_OUT_SEL];
			end
			if (w_to_ev)
				wctl_reg[`DCT_BIT_TIMEOUT] <= 1'b1;
			else if (wr_wctl && reg_wdata[`DCT_BIT_TIMEOUT])
				wctl_reg[`DCT_BIT_TIMEOUT] <= 1'b0;
			if (stop_recover) begin
				wctl_reg[`DCT_BIT_ENABLE]  <= 1'b0; // RULE9
				wctl_reg[`DCT_BIT_MODE]    <= 1'b0; // RULE9
				wctl_reg[`DCT_BIT_OUT_SEL] <= 1'b0; // RULE9
			end
		end
	end

	// hold registers: no interlock against a write during a reload
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_lo_hold_reg <= `DCT_ZERO8;
			s_hi_hold_reg <= `DCT_ZERO8;
			w_lo_hold_reg <= `DCT_ZERO8;
			w_hi_hold_reg <= `DCT_ZERO8;
		end else if (reg_wr) begin
			case (reg_addr)
				`DCT_OFS_SHORT_LO_HOLD: s_lo_hold_reg <= reg_wdata;
				`DCT_OFS_SHORT_HI_HOLD: s_hi_hold_reg <= reg_wdata;
				`DCT_OFS_WIDE_LO_HOLD:  w_lo_hold_reg <= reg_wdata;
				`DCT_OFS_WIDE_HI_HOLD:  w_hi_hold_reg <= reg_wdata;
				default: ;
			endcase
		end
	end

	// interrupt request pulses
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			short_capture_irq <= 1'b0;
			short_timeout_irq <= 1'b0;
			wide_capture_irq  <= 1'b0;
			wide_timeout_irq  <= 1'b0;
		end else begin
			short_capture_irq <= s_cap_ev && sctl_reg[`DCT_BIT_CAP_MASK]; // RULE5
			short_timeout_irq <= s_to_ev && sctl_reg[`DCT_BIT_TO_MASK]; // RULE8
			wide_capture_irq  <= w_cap_ev && wctl_reg[`DCT_BIT_CAP_MASK]; // RULE18
			wide_timeout_irq  <= w_to_ev && wctl_reg[`DCT_BIT_TO_MASK]; // RULE8
		end
	end

	// registered read port; unmapped offsets read zero
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			reg_rdata <= `DCT_ZERO8;
		else if (reg_rd) begin
			case (reg_addr)
				`DCT_OFS_SHORT_CTRL:    reg_rdata <= sctl_reg;
				`DCT_OFS_EDGE_CTRL:     reg_rdata <= {2'b00, esel_reg, 2'b00, rise_flag_reg, fall_flag_reg};
				`DCT_OFS_WIDE_CTRL:     reg_rdata <= wctl_reg;
				`DCT_OFS_SHORT_LO_HOLD: reg_rdata <= s_lo_hold_reg;
				`DCT_OFS_SHORT_HI_HOLD: reg_rdata <= s_hi_hold_reg;
				`DCT_OFS_WIDE_LO_HOLD:  reg_rdata <= w_lo_hold_reg;
				`DCT_OFS_WIDE_HI_HOLD:  reg_rdata <= w_hi_hold_reg;
				`DCT_OFS_SHORT_CAP_LO:  reg_rdata <= s_cap_lo_reg;
				`DCT_OFS_SHORT_CAP_HI:  reg_rdata <= s_cap_hi_reg;
				`DCT_OFS_WIDE_CAP_LO:   reg_rdata <= w_cap_reg[7:0];
				`DCT_OFS_WIDE_CAP_HI:   reg_rdata <= w_cap_reg[15:8];
				default:                reg_rdata <= `DCT_ZERO8;
			endcase
		end
	end

endmodule

`default_nettype wire
